// File: rtl/tcrt_map.svh
// tcrt_map.svh: register offsets, field positions, reset values and clock divisors
// assumes classic wishbone with 32-bit data, byte addresses, one register per word
`ifndef TCRT_MAP_SVH
`define TCRT_MAP_SVH

// per-timer block of eight words, timer n at n * TCRT_TIMER_STRIDE
`define TCRT_TIMER_STRIDE 8'h20
`define TCRT_OFS_COUNT_LO 3'd0
`define TCRT_OFS_COUNT_HI 3'd1
`define TCRT_OFS_CAPRL_LO 3'd2
`define TCRT_OFS_CAPRL_HI 3'd3
`define TCRT_OFS_CONTROL 3'd4
`define TCRT_OFS_CONFIG 3'd5

// control register fields
`define TCRT_CN_CAPRL_SEL 0
`define TCRT_CN_COUNTER_SEL 1
`define TCRT_CN_RUN 2
`define TCRT_CN_EXT_EN 3
`define TCRT_CN_EXT_FLAG 6
`define TCRT_CN_OVF_FLAG 7

// config register fields
`define TCRT_CF_DEC_EN 0
`define TCRT_CF_OUT_EN 1
`define TCRT_CF_TOGGLE 2
`define TCRT_CF_CLKSEL_LO 3
`define TCRT_CF_CLKSEL_HI 4

`define TCRT_RESET_BYTE 8'h00
`define TCRT_COUNT_MAX 16'hffff
`define TCRT_COUNT_ZERO 16'h0000

// clock divisors
`define TCRT_DIV_SYS12 4'd12
`define TCRT_DIV_EXT8 3'd7

`endif

// File: rtl/tcrt_pkg.sv
// tcrt_pkg.sv: types shared by the timer block
// assumes tcrt_map.svh is compiled alongside
package tcrt_pkg;

    // clock select field encodings
    typedef enum logic [1:0] {
        TCRT_CLK_SYS,
        TCRT_CLK_SYS2,
        TCRT_CLK_SYS12,
        TCRT_CLK_EXT8
    } tcrt_clksel_type;

    // bus slave phase
    typedef enum logic {
        TCRT_BUS_IDLE,
        TCRT_BUS_ACK
    } tcrt_bus_type;

    // one timer's software-visible state
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] caprl;
        logic ovf_flag;
        logic ext_flag;
        logic ext_en;
        logic run;
        logic counter_sel;
        logic caprl_sel;
        logic dec_en;
        logic out_en;
        logic toggle;
        logic [1:0] clksel;
    } tcrt_timer_type;

endpackage : tcrt_pkg

// File: rtl/tcrt_timers.sv
// tcrt_timers.sv: three 16-bit counter/timers with capture and reload, toggle on timers 0 and 2
// assumes a classic wishbone master on i_core_clk and asynchronous pins
//
// The Wishbone slave port and the register offsets were decided locally.
`include "tcrt_map.svh"
`timescale 1ns/100ps
module tcrt_timers #(
    parameter int NUM_TIMERS = 3
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // external oscillator clock level, sampled on the core clock
    input wire logic i_ext_osc,
    // count and trigger pins: timers 0 and 1 share the first pair
    input wire logic i_first_count_pin,
    input wire logic i_shared_trigger_pin,
    input wire logic i_third_count_pin,
    input wire logic i_third_trigger_pin,
    // toggle outputs of timers 0 and 2
    output logic o_first_toggle_pin,
    output logic o_first_toggle_oe,
    output logic o_third_output_pin,
    output logic o_third_output_oe,
    // wrap and capture events, one-cycle pulses
    output logic [2:0] o_wrap_event,
    output logic [2:0] o_ovf_irq,
    output logic [2:0] o_ext_irq
);
    import tcrt_pkg::*;

    typedef struct packed {
        tcrt_timer_type [2:0] tmr;
        tcrt_bus_type bus;
        logic [31:0] rdata;
        logic [3:0] div12;
        logic div2;
        logic [2:0] ext_div;
        logic [2:0] ext_sync;
        logic [2:0] cnt0_sync;
        logic [2:0] trg0_sync;
        logic [2:0] cnt2_sync;
        logic [2:0] trg2_sync;
        logic [2:0] wrap;
        logic [2:0] ovf_irq;
        logic [2:0] ext_irq;
    } tcrt_state_type;

    tcrt_state_type state_reg;
    tcrt_state_type state_next;

    function automatic logic tick_sel(input logic [1:0] sel, input logic e2,
                                      input logic e12, input logic e8);
        case (tcrt_clksel_type'(sel))
            TCRT_CLK_SYS: tick_sel = 1'b1;
            TCRT_CLK_SYS2: tick_sel = e2;
            TCRT_CLK_SYS12: tick_sel = e12;
            TCRT_CLK_EXT8: tick_sel = e8;
            default: tick_sel = 1'b0;
        endcase
    endfunction : tick_sel

    // byte lane write helper for 8-bit registers in lane 0
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel,
                                         input logic [31:0] dat);
        lane0 = sel[0] ? dat[7:0] : old;
    endfunction : lane0

    logic en2;
    logic en12;
    logic en8;
    logic [2:0] cnt_fall;
    logic [2:0] trg_fall;
    logic [2:0] trg_level;

    // prescalers and pin edges; only stage 1 and 2 of each synchroniser are read
    always_comb begin
        en2 = state_reg.div2;
        en12 = (state_reg.div12 == 4'(`TCRT_DIV_SYS12 - 4'd1));
        en8 = state_reg.ext_sync[2] & ~state_reg.ext_sync[1]
              & (state_reg.ext_div == `TCRT_DIV_EXT8);
        cnt_fall[0] = state_reg.cnt0_sync[2] & ~state_reg.cnt0_sync[1];
        trg_fall[0] = state_reg.trg0_sync[2] & ~state_reg.trg0_sync[1];
        cnt_fall[1] = cnt_fall[0];
        trg_fall[1] = trg_fall[0];
        cnt_fall[2] = state_reg.cnt2_sync[2] & ~state_reg.cnt2_sync[1];
        trg_fall[2] = state_reg.trg2_sync[2] & ~state_reg.trg2_sync[1];
        trg_level[0] = state_reg.trg0_sync[1];
        trg_level[1] = state_reg.trg0_sync[1];
        trg_level[2] = state_reg.trg2_sync[1];
    end

    logic bus_req;
    logic [2:0] bus_tsel;
    logic [2:0] bus_ofs;
    logic bus_hit;

    always_comb begin
        bus_req = i_wb_cyc & i_wb_stb & (state_reg.bus == TCRT_BUS_IDLE);
        bus_tsel = 3'(i_wb_adr[7:5]);
        bus_ofs = i_wb_adr[4:2];
        bus_hit = (bus_tsel < 3'(NUM_TIMERS)) && (bus_ofs <= `TCRT_OFS_CONFIG);
    end

    always_comb begin
        logic tick;
        logic up;
        logic wrap;
        logic trig;
        logic [15:0] cnt;
        logic [7:0] rb;
        tick = 1'b0;
        up = 1'b1;
        wrap = 1'b0;
        trig = 1'b0;
        cnt = 16'h0000;
        rb = 8'h00;
        state_next = state_reg;
        state_next.div2 = ~state_reg.div2;
        state_next.div12 = en12 ? 4'h0 : state_reg.div12 + 4'h1;
        // external clock divided by 8, counted on its falling edges
        if (state_reg.ext_sync[2] & ~state_reg.ext_sync[1]) begin
            state_next.ext_div = state_reg.ext_div + 3'h1;
        end
        state_next.ext_sync = {state_reg.ext_sync[1:0], i_ext_osc};
        state_next.cnt0_sync = {state_reg.cnt0_sync[1:0], i_first_count_pin};
        state_next.trg0_sync = {state_reg.trg0_sync[1:0], i_shared_trigger_pin};
        state_next.cnt2_sync = {state_reg.cnt2_sync[1:0], i_third_count_pin};
        state_next.trg2_sync = {state_reg.trg2_sync[1:0], i_third_trigger_pin};
        state_next.wrap = 3'h0;
        state_next.ovf_irq = 3'h0;
        state_next.ext_irq = 3'h0;

        // software writes first, so hardware events below win over a clear
        if (bus_req && i_wb_we && bus_hit) begin
            case (bus_ofs)
                `TCRT_OFS_COUNT_LO: state_next.tmr[bus_tsel].count[7:0] =
                    lane0(state_reg.tmr[bus_tsel].count[7:0], i_wb_sel, i_wb_dat);
                `TCRT_OFS_COUNT_HI: state_next.tmr[bus_tsel].count[15:8] =
                    lane0(state_reg.tmr[bus_tsel].count[15:8], i_wb_sel, i_wb_dat);
                `TCRT_OFS_CAPRL_LO: state_next.tmr[bus_tsel].caprl[7:0] =
                    lane0(state_reg.tmr[bus_tsel].caprl[7:0], i_wb_sel, i_wb_dat);
                `TCRT_OFS_CAPRL_HI: state_next.tmr[bus_tsel].caprl[15:8] =
                    lane0(state_reg.tmr[bus_tsel].caprl[15:8], i_wb_sel, i_wb_dat);
                `TCRT_OFS_CONTROL: begin
                    if (i_wb_sel[0]) begin
                        state_next.tmr[bus_tsel].ovf_flag = i_wb_dat[`TCRT_CN_OVF_FLAG];
                        state_next.tmr[bus_tsel].ext_flag = i_wb_dat[`TCRT_CN_EXT_FLAG];
                        state_next.tmr[bus_tsel].ext_en = i_wb_dat[`TCRT_CN_EXT_EN];
                        state_next.tmr[bus_tsel].run = i_wb_dat[`TCRT_CN_RUN];
                        state_next.tmr[bus_tsel].counter_sel = i_wb_dat[`TCRT_CN_COUNTER_SEL];
                        state_next.tmr[bus_tsel].caprl_sel = i_wb_dat[`TCRT_CN_CAPRL_SEL];
                    end
                end
                `TCRT_OFS_CONFIG: begin
                    if (i_wb_sel[0]) begin
                        state_next.tmr[bus_tsel].dec_en = i_wb_dat[`TCRT_CF_DEC_EN];
                        // timer 1 has no toggle output
                        if (bus_tsel != 3'd1) begin
                            state_next.tmr[bus_tsel].out_en = i_wb_dat[`TCRT_CF_OUT_EN];
                            state_next.tmr[bus_tsel].toggle = i_wb_dat[`TCRT_CF_TOGGLE];
                        end
                        state_next.tmr[bus_tsel].clksel =
                            i_wb_dat[`TCRT_CF_CLKSEL_HI:`TCRT_CF_CLKSEL_LO];
                    end
                end
                default: ;
            endcase
        end

        for (int n = 0; n < 3; n++) begin
            tick = state_reg.tmr[n].counter_sel ? cnt_fall[n]
                 : tick_sel(state_reg.tmr[n].clksel, en2, en12, en8);
            tick = tick & state_reg.tmr[n].run;
            up = ~state_reg.tmr[n].dec_en | trg_level[n];
            trig = trg_fall[n] & state_reg.tmr[n].ext_en & ~state_reg.tmr[n].dec_en;
            cnt = state_next.tmr[n].count;
            wrap = 1'b0;
            if (state_reg.tmr[n].caprl_sel) begin
                if (trig) begin
                    state_next.tmr[n].caprl = state_reg.tmr[n].count;
                    state_next.tmr[n].ext_flag = 1'b1;
                    state_next.ext_irq[n] = 1'b1;
                end
                if (tick) begin
                    if (up) begin
                        wrap = (cnt == `TCRT_COUNT_MAX);
                        cnt = cnt + 16'h1;
                    end else begin
                        wrap = (cnt == `TCRT_COUNT_ZERO);
                        cnt = cnt - 16'h1;
                    end
                end
            end else begin
                if (tick) begin
                    if (up) begin
                        wrap = (cnt == `TCRT_COUNT_MAX);
                        cnt = wrap ? state_next.tmr[n].caprl : cnt + 16'h1;
                    end else begin
                        wrap = (cnt == state_next.tmr[n].caprl);
                        cnt = wrap ? `TCRT_COUNT_MAX : cnt - 16'h1;
                    end
                end
                if (trig) begin
                    cnt = state_next.tmr[n].caprl;
                end
                if (wrap) begin
                    state_next.tmr[n].ext_flag = ~state_next.tmr[n].ext_flag;
                end
            end
            state_next.tmr[n].count = cnt;
            if (wrap) begin
                state_next.tmr[n].ovf_flag = 1'b1;
                state_next.ovf_irq[n] = 1'b1;
                state_next.wrap[n] = 1'b1;
                if (n != 1 && state_reg.tmr[n].out_en) begin
                    state_next.tmr[n].toggle = ~state_next.tmr[n].toggle;
                end
            end
        end

        // bus slave: ack one cycle after the request, then drop
        state_next.bus = TCRT_BUS_IDLE;
        if (bus_req) begin
            state_next.bus = TCRT_BUS_ACK;
            case (bus_ofs)
                `TCRT_OFS_COUNT_LO: rb = state_reg.tmr[bus_tsel].count[7:0];
                `TCRT_OFS_COUNT_HI: rb = state_reg.tmr[bus_tsel].count[15:8];
                `TCRT_OFS_CAPRL_LO: rb = state_reg.tmr[bus_tsel].caprl[7:0];
                `TCRT_OFS_CAPRL_HI: rb = state_reg.tmr[bus_tsel].caprl[15:8];
                `TCRT_OFS_CONTROL: begin
                    rb[`TCRT_CN_OVF_FLAG] = state_reg.tmr[bus_tsel].ovf_flag;
                    rb[`TCRT_CN_EXT_FLAG] = state_reg.tmr[bus_tsel].ext_flag;
                    rb[`TCRT_CN_EXT_EN] = state_reg.tmr[bus_tsel].ext_en;
                    rb[`TCRT_CN_RUN] = state_reg.tmr[bus_tsel].run;
                    rb[`TCRT_CN_COUNTER_SEL] = state_reg.tmr[bus_tsel].counter_sel;
                    rb[`TCRT_CN_CAPRL_SEL] = state_reg.tmr[bus_tsel].caprl_sel;
                end
                `TCRT_OFS_CONFIG: begin
                    rb[`TCRT_CF_DEC_EN] = state_reg.tmr[bus_tsel].dec_en;
                    rb[`TCRT_CF_OUT_EN] = state_reg.tmr[bus_tsel].out_en;
                    rb[`TCRT_CF_TOGGLE] = state_reg.tmr[bus_tsel].toggle;
                    rb[`TCRT_CF_CLKSEL_HI:`TCRT_CF_CLKSEL_LO] = state_reg.tmr[bus_tsel].clksel;
                end
                default: rb = 8'h00;
            endcase
            // unmapped addresses read zero and ignore writes
            state_next.rdata = bus_hit ? {24'h000000, rb} : 32'h00000000;
        end
    end

    // single state register; reset loads constants only
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flip-flops
    always_comb begin
        o_wb_ack = (state_reg.bus == TCRT_BUS_ACK);
        o_wb_dat = state_reg.rdata;
        o_first_toggle_pin = state_reg.tmr[0].toggle;
        o_first_toggle_oe = state_reg.tmr[0].out_en;
        o_third_output_pin = state_reg.tmr[2].toggle;
        o_third_output_oe = state_reg.tmr[2].out_en;
        o_wrap_event = state_reg.wrap;
        o_ovf_irq = state_reg.ovf_irq;
        o_ext_irq = state_reg.ext_irq;
    end

endmodule : tcrt_timers

// File: tb/tcrt_pin_model.sv
// tcrt_pin_model.sv: external oscillator, count and trigger pins
// assumes the bench calls pulse and set_pin; pins move just after an edge
`timescale 1ns/100ps
module tcrt_pin_model (
    input wire logic i_core_clk,
    output logic o_ext_osc,
    output logic o_first_count_pin,
    output logic o_shared_trigger_pin,
    output logic o_third_count_pin,
    output logic o_third_trigger_pin
);
    logic [1:0] osc_reg = 2'h0;
    logic [3:0] pins_reg = 4'h5;
    // oscillator runs free at a quarter of the core rate
    always @(posedge i_core_clk) begin
        osc_reg <= osc_reg + 2'h1;
    end
    // pin order: first count, shared trigger, third count, third trigger
    assign o_ext_osc = osc_reg[1];
    assign {o_third_trigger_pin, o_third_count_pin} = pins_reg[3:2];
    assign {o_shared_trigger_pin, o_first_count_pin} = pins_reg[1:0];
    // each level held six cycles, well past the three-flop synchroniser
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            pins_reg[idx] <= 1'b0;
            repeat (6) @(posedge i_core_clk);
            pins_reg[idx] <= 1'b1;
            repeat (6) @(posedge i_core_clk);
        end
    endtask : pulse
    task automatic set_pin(input int idx, input logic v);
        @(posedge i_core_clk);
        pins_reg[idx] <= v;
        repeat (8) @(posedge i_core_clk);
    endtask : set_pin
endmodule : tcrt_pin_model

// File: tb/tcrt_timers_properties.sv
// tcrt_timers_properties.sv: port-level checks of the timer block
// assumes one core clock domain; bound to every tcrt_timers instance
`timescale 1ns/100ps
module tcrt_checker (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic i_shared_trigger_pin,
    input wire logic i_third_trigger_pin,
    input wire logic o_first_toggle_pin,
    input wire logic o_first_toggle_oe,
    input wire logic [2:0] o_wrap_event,
    input wire logic [2:0] o_ovf_irq,
    input wire logic [2:0] o_ext_irq
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    logic [3:0] since1_reg;
    logic [3:0] since3_reg;
    // cycles since each trigger pin last fell, saturating so it never wraps
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            since1_reg <= 4'hf;
            since3_reg <= 4'hf;
        end else begin
            since1_reg <= $fell(i_shared_trigger_pin) ? 4'h0 : since1_reg + 4'(since1_reg != 4'hf);
            since3_reg <= $fell(i_third_trigger_pin) ? 4'h0 : since3_reg + 4'(since3_reg != 4'hf);
        end
    end
    property p_ack_next;
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
    endproperty
    property p_ack_pulse;
        o_wb_ack |=> !o_wb_ack;
    endproperty
    property p_ack_cause;
        o_wb_ack |-> $past(i_wb_cyc && i_wb_stb);
    endproperty
    property p_unmapped;
        o_wb_ack && $past(!i_wb_we && (i_wb_adr[7:5] > 3'h2 || i_wb_adr[4:2] > 3'h5))
            |-> o_wb_dat == 32'h0;
    endproperty
    property p_ovf_wrap;
        (o_ovf_irq & ~o_wrap_event) == 3'h0;
    endproperty
    property p_toggle_cause;
        $changed(o_first_toggle_pin) |-> o_wrap_event[0] || $past(o_wrap_event[0]) || o_wb_ack;
    endproperty
    property p_oe_write;
        $changed(o_first_toggle_oe) |-> o_wb_ack && $past(i_wb_we);
    endproperty
    property p_ext_cause3;
        o_ext_irq[2] |-> since3_reg < 4'ha;
    endproperty
    property p_ext_cause1;
        |o_ext_irq[1:0] |-> since1_reg < 4'ha;
    endproperty
    property p_ext_pulse;
        o_ext_irq[2] |=> !o_ext_irq[2];
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow without wrap");
    a_toggle_cause: assert property (p_toggle_cause) else $error("toggle moved");
    a_oe_write: assert property (p_oe_write) else $error("output enable moved");
    a_ext_cause3: assert property (p_ext_cause3) else $error("capture without edge");
    a_ext_cause1: assert property (p_ext_cause1) else $error("shared capture");
    a_ext_pulse: assert property (p_ext_pulse) else $error("capture pulse long");
    c_wrap0: cover property (o_wrap_event[0]);
    c_capture: cover property (o_ext_irq[2]);
    c_ovf: cover property (|o_ovf_irq);
endmodule : tcrt_checker

bind tcrt_timers tcrt_checker u_chk (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_shared_trigger_pin(i_shared_trigger_pin),
    .i_third_trigger_pin(i_third_trigger_pin), .o_first_toggle_pin(o_first_toggle_pin),
    .o_first_toggle_oe(o_first_toggle_oe), .o_wrap_event(o_wrap_event),
    .o_ovf_irq(o_ovf_irq), .o_ext_irq(o_ext_irq));

// File: tb/tcrt_timers_tb.sv
// tcrt_timers_tb.sv: register-level tests of the timer block
// assumes the pin model on the far side and the bound checker
`timescale 1ns/100ps
module tcrt_timers_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack, osc, cnt1, trg1, cnt3, trg3, tg1, oe1, tg3, oe3, b;
    logic [2:0] wrap, ovf, ext;
    int mismatches = 0;
    int samples_checked = 0;
    int n;
    int per[4] = '{16, 32, 192, 512};

    tcrt_timers #(.NUM_TIMERS(3)) u_dut (.i_core_clk(clk), .i_reset(rst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_ext_osc(osc), .i_first_count_pin(cnt1),
        .i_shared_trigger_pin(trg1), .i_third_count_pin(cnt3), .i_third_trigger_pin(trg3),
        .o_first_toggle_pin(tg1), .o_first_toggle_oe(oe1), .o_third_output_pin(tg3),
        .o_third_output_oe(oe3), .o_wrap_event(wrap), .o_ovf_irq(ovf), .o_ext_irq(ext));
    tcrt_pin_model u_pins (.i_core_clk(clk), .o_ext_osc(osc), .o_first_count_pin(cnt1),
        .o_shared_trigger_pin(trg1), .o_third_count_pin(cnt3), .o_third_trigger_pin(trg3));

    // 250 MHz core clock
    always #2 clk = ~clk;

    task automatic summarize();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // one classic cycle; ack is looked at on the edge that the design answers on
    task automatic bus(input logic w, input int t, input int wd, input logic [7:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= 8'(t * 32 + wd * 4);
        wdat <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        check("wb_ack", 32'h1, {31'h0, ack});
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic wr(input int t, input int wd, input logic [7:0] d);
        bus(1'b1, t, wd, d);
    endtask : wr
    task automatic rd(input int t, input int wd, input logic [7:0] e, input string name);
        bus(1'b0, t, wd, 8'h00);
        check(name, {24'h0, e}, q);
    endtask : rd
    task automatic set16(input int t, input int wd, input logic [15:0] v);
        wr(t, wd, v[7:0]);
        wr(t, wd + 1, v[15:8]);
    endtask : set16
    task automatic rd16(input int t, input int wd, input logic [15:0] e, input string name);
        rd(t, wd, e[7:0], name);
        rd(t, wd + 1, e[15:8], name);
    endtask : rd16
    // counts edges until the timer's wrap pulse, bounded
    task automatic wait_wrap(input int i);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wrap[i] !== 1'b1 && n < 2000);
    endtask : wait_wrap

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(0, 4, 8'h00, "ctl0_reset");
        set16(0, 2, 16'hfff0);
        set16(0, 0, 16'hfff0);
        wr(0, 4, 8'h04);
        for (int k = 0; k < 4; k++) begin
            wr(0, 5, 8'(k * 8 + 2));
            wait_wrap(0);
            wait_wrap(0);
            wait_wrap(0);
            check("period", 32'(per[k]), 32'(n));
            @(posedge clk);
            b = tg1;
            wait_wrap(0);
            @(posedge clk);
            check("toggle", {31'h0, ~b}, {31'h0, tg1});
        end
        wr(0, 5, 8'h12);
        wr(0, 4, 8'h04);
        wait_wrap(0);
        rd(0, 4, 8'hc4, "ctl0_wrap");
        // keep the external flag set so the next wrap must clear it
        wr(0, 4, 8'h44);
        wait_wrap(0);
        rd(0, 4, 8'h84, "ctl0_ext_toggle");
        wr(0, 4, 8'h00);
        wr(0, 5, 8'h06);
        rd(0, 5, 8'h06, "cfg0_force1");
        check("oe1", 32'h1, {31'h0, oe1});
        check("toggle_force1", 32'h1, {31'h0, tg1});
        wr(0, 5, 8'h02);
        check("toggle_force0", 32'h0, {31'h0, tg1});
        // timer 2 counts pin edges, capture mode, then reload mode
        set16(2, 0, 16'h0001);
        wr(2, 5, 8'h01);
        wr(2, 4, 8'h07);
        u_pins.pulse(2, 2);
        rd16(2, 0, 16'hffff, "cnt2_under");
        rd(2, 4, 8'h87, "ctl2_under");
        u_pins.set_pin(3, 1'b1);
        wr(2, 4, 8'h07);
        u_pins.pulse(2, 1);
        rd16(2, 0, 16'h0000, "cnt2_over");
        rd(2, 4, 8'h87, "ctl2_over");
        wr(2, 4, 8'h0f);
        u_pins.set_pin(3, 1'b0);
        rd16(2, 2, 16'h0000, "cap2_dir_only");
        rd(2, 4, 8'h0f, "ctl2_dir_only");
        wr(2, 5, 8'h00);
        set16(2, 0, 16'h1234);
        u_pins.set_pin(3, 1'b1);
        u_pins.set_pin(3, 1'b0);
        rd16(2, 2, 16'h1234, "cap2");
        rd(2, 4, 8'h4f, "ctl2_cap");
        wr(2, 4, 8'h07);
        set16(2, 0, 16'h5678);
        u_pins.set_pin(3, 1'b1);
        u_pins.set_pin(3, 1'b0);
        rd16(2, 2, 16'h1234, "cap2_ignored");
        wr(2, 4, 8'h0e);
        u_pins.set_pin(3, 1'b1);
        u_pins.set_pin(3, 1'b0);
        rd16(2, 0, 16'h1234, "cnt2_reload");
        wr(2, 5, 8'h01);
        wr(2, 4, 8'h06);
        u_pins.pulse(2, 1);
        rd16(2, 0, 16'hffff, "cnt2_match");
        rd(2, 4, 8'hc6, "ctl2_match");
        wr(2, 5, 8'h07);
        check("toggle3", 32'h1, {31'h0, tg3});
        check("oe3", 32'h1, {31'h0, oe3});
        // timers 0 and 1 watch the same pins, in opposite directions
        set16(0, 0, 16'h0000);
        set16(1, 0, 16'h0000);
        wr(1, 5, 8'h07);
        wr(0, 5, 8'h00);
        wr(0, 4, 8'h06);
        wr(1, 4, 8'h06);
        u_pins.pulse(0, 3);
        rd16(0, 0, 16'h0003, "cnt0_shared");
        rd16(1, 0, 16'hfffd, "cnt1_down");
        rd(1, 5, 8'h01, "cfg1_no_toggle");
        // timer 1 captures from the shared trigger, timer 0 ignores it
        wr(1, 5, 8'h00);
        wr(1, 4, 8'h0f);
        u_pins.set_pin(1, 1'b1);
        u_pins.set_pin(1, 1'b0);
        rd16(1, 2, 16'hfffd, "cap1_shared");
        rd(1, 4, 8'h4f, "ctl1_cap");
        rd(0, 4, 8'h06, "ctl0_no_cap");
        wr(3, 0, 8'h5a);
        rd(3, 0, 8'h00, "unmapped_t3");
        rd(0, 6, 8'h00, "unmapped_w6");
        summarize();
    end

    // watchdog, several times the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule : tcrt_timers_tb
